// file: rps_pkg.sv
// constants for the reset and test-port sequencer
// assumes a single 20 MHz core clock; the clock period and the slow-clock cycle counts below derive from it
package rps_pkg;

  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned RESET_MIN_CYCLES  = 6;
  localparam int unsigned TEST_RESET_EDGES  = 6;
  localparam int unsigned SLOW_MIN_NS       = 740;
  localparam int unsigned SLOW_MAX_NS       = 1600;
  localparam int unsigned SLOW_PERIOD_NS    = 1000;
  localparam int unsigned SLOW_MIN_CYCLES   = (SLOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOW_MAX_CYCLES   = SLOW_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOW_PERIOD_CYC   = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  SLOW_HALF_CYCLES  = 5'(SLOW_PERIOD_CYC / 2);
  localparam logic [2:0]  RESET_CNT_MAX     = 3'(RESET_MIN_CYCLES);
  localparam logic [2:0]  TEST_EDGE_MAX     = 3'(TEST_RESET_EDGES);
  localparam logic [2:0]  CNT3_ZERO         = 3'h0;
  localparam logic [2:0]  CNT3_ONE          = 3'h1;
  localparam logic [4:0]  SLOW_CNT_ONE      = 5'h1;

  typedef enum logic [1:0]
  {
    RPS_POWERUP = 2'b00,
    RPS_RESET   = 2'b01,
    RPS_RUN     = 2'b10
  } rps_state_t;

endpackage : rps_pkg

// file: rps_sequencer.sv
// reset, test-port reset and clock-output sequencing for the signal processor
// assumes core-side inputs are on clk_in; pin inputs are synchronised here
// Function
// - power-up reset clears the test controller
// - reset with interrupt zero: pins high impedance
// - reset alone: strobes high, clock output runs
// - above 50 MIPS the PLL is mandatory
// - slow clock output period 0.74 to 1.6 us
module rps_sequencer
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic chip_reset_n_in,
  input  wire logic interrupt_zero_input_in,
  input  wire logic test_clock_in,
  input  wire logic test_mode_select_in,
  input  wire logic test_data_oe_n_in,
  input  wire logic pll_enable_in,
  input  wire logic speed_above_50_in,
  input  wire logic slow_clock_select_in,
  input  wire logic core_rom_enable_in,
  input  wire logic core_ram_high_enable_in,
  input  wire logic core_ram_low_enable_in,
  input  wire logic core_io_enable_in,
  input  wire logic core_device_select_in,
  input  wire logic core_write_strobe_n_in,
  output logic      ext_rom_enable_out,
  output logic      ext_ram_high_enable_out,
  output logic      ext_ram_low_enable_out,
  output logic      io_enable_out,
  output logic      device_select_out,
  output logic      write_strobe_n_out,
  output logic      clock_output_out,
  output logic      pin_oe_n_out,
  output logic      test_data_oe_n_out,
  output logic      test_reset_out,
  output logic      core_reset_out,
  output logic      reset_too_short_out,
  output logic      pll_in_use_out,
  output logic      clock_mode_fault_out
);

  // synchronisers: first stage feeds only the second
  logic tck_s1_reg, tck_s2_reg, tms_s1_reg, tms_s2_reg;
  logic rstn_s1_reg, rstn_s2_reg, interrupt_zero_input_s1_reg, interrupt_zero_input_s2_reg;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tck_s1_reg  <= 1'b0;
      tck_s2_reg  <= 1'b0;
      tms_s1_reg  <= 1'b1;
      tms_s2_reg  <= 1'b1;
      rstn_s1_reg <= 1'b0;
      rstn_s2_reg <= 1'b0;
      interrupt_zero_input_s1_reg <= 1'b0;
      interrupt_zero_input_s2_reg <= 1'b0;
    end
    else
    begin
      tck_s1_reg  <= test_clock_in;
      tck_s2_reg  <= tck_s1_reg;
      tms_s1_reg  <= test_mode_select_in;
      tms_s2_reg  <= tms_s1_reg;
      rstn_s1_reg <= chip_reset_n_in;
      rstn_s2_reg <= rstn_s1_reg;
      interrupt_zero_input_s1_reg <= interrupt_zero_input_in;
      interrupt_zero_input_s2_reg <= interrupt_zero_input_s1_reg;
    end
  end

  rps_pkg::rps_state_t state_reg, state_next;
  logic [2:0] rst_cnt_reg, rst_cnt_next;
  logic [2:0] edge_cnt_reg, edge_cnt_next;
  logic [4:0] slow_cnt_reg, slow_cnt_next;
  logic       tck_prev_reg, tck_prev_next;
  logic       test_reset_next, core_reset_next, short_next;
  logic       clk_out_next, pin_oe_n_next, tdo_oe_n_next;
  logic       rom_next, ramh_next, raml_next, io_next, device_select_out_next, wsn_next;
  logic       pll_next, fault_next;
  logic       chip_reset, tck_rise;

  always_comb
  begin
    chip_reset      = !rstn_s2_reg;
    tck_rise        = tck_s2_reg && !tck_prev_reg;
    tck_prev_next   = tck_s2_reg;
    state_next      = state_reg;
    rst_cnt_next    = rst_cnt_reg;
    short_next      = reset_too_short_out;
    edge_cnt_next   = edge_cnt_reg;
    test_reset_next = test_reset_out;
    // test controller: six rising TCK edges with TMS high enter its reset state
    if (tck_rise)
    begin
      if (tms_s2_reg)
      begin
        if (edge_cnt_reg < rps_pkg::TEST_EDGE_MAX - rps_pkg::CNT3_ONE)
          edge_cnt_next = edge_cnt_reg + rps_pkg::CNT3_ONE;
        else
        begin
          edge_cnt_next   = rps_pkg::TEST_EDGE_MAX;
          test_reset_next = 1'b1;
        end
      end
      else
      begin
        edge_cnt_next   = rps_pkg::CNT3_ZERO;
        test_reset_next = 1'b0;
      end
    end
    // chip reset sequencing; a release before six cycles is ignored
    case (state_reg)
      rps_pkg::RPS_POWERUP:
      begin
        if (chip_reset)
        begin
          state_next   = rps_pkg::RPS_RESET;
          rst_cnt_next = rps_pkg::CNT3_ONE;
        end
      end
      rps_pkg::RPS_RESET:
      begin
        if (chip_reset)
        begin
          if (rst_cnt_reg < rps_pkg::RESET_CNT_MAX)
            rst_cnt_next = rst_cnt_reg + rps_pkg::CNT3_ONE;
        end
        else if (rst_cnt_reg >= rps_pkg::RESET_CNT_MAX)
        begin
          state_next = rps_pkg::RPS_RUN;
          short_next = 1'b0;
        end
        else
        begin
          short_next   = 1'b1;
          rst_cnt_next = rps_pkg::CNT3_ZERO;
        end
      end
      rps_pkg::RPS_RUN:
      begin
        if (chip_reset)
        begin
          state_next   = rps_pkg::RPS_RESET;
          rst_cnt_next = rps_pkg::CNT3_ONE;
        end
      end
      default:
      begin
        state_next   = rps_pkg::RPS_POWERUP;
        rst_cnt_next = rps_pkg::CNT3_ZERO;
      end
    endcase
    core_reset_next = (state_next != rps_pkg::RPS_RUN);
    // direct clock only allowed at low speed
    pll_next   = pll_enable_in || speed_above_50_in;
    fault_next = !pll_enable_in && speed_above_50_in;
    // clock output keeps running through reset; slow mode divides further
    slow_cnt_next = rps_pkg::SLOW_CNT_ONE;
    clk_out_next  = !clock_output_out;
    if (slow_clock_select_in)
    begin
      if (slow_cnt_reg >= rps_pkg::SLOW_HALF_CYCLES)
        slow_cnt_next = rps_pkg::SLOW_CNT_ONE;
      else
      begin
        slow_cnt_next = slow_cnt_reg + rps_pkg::SLOW_CNT_ONE;
        clk_out_next  = clock_output_out;
      end
    end
    pin_oe_n_next = chip_reset && interrupt_zero_input_s2_reg;
    tdo_oe_n_next = test_data_oe_n_in;
    rom_next  = chip_reset || core_rom_enable_in;
    ramh_next = chip_reset || core_ram_high_enable_in;
    raml_next = chip_reset || core_ram_low_enable_in;
    io_next   = chip_reset || core_io_enable_in;
    device_select_out_next = chip_reset || core_device_select_in;
    wsn_next  = chip_reset || core_write_strobe_n_in;
  end

  // power-up reset puts the test controller straight into its reset state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg               <= rps_pkg::RPS_POWERUP;
      rst_cnt_reg             <= 3'h0;
      edge_cnt_reg            <= 3'h0;
      slow_cnt_reg            <= 5'h1;
      tck_prev_reg            <= 1'b0;
      test_reset_out          <= 1'b1;
      core_reset_out          <= 1'b1;
      reset_too_short_out     <= 1'b0;
      clock_output_out        <= 1'b0;
      pin_oe_n_out            <= 1'b1;
      test_data_oe_n_out      <= 1'b1;
      ext_rom_enable_out      <= 1'b1;
      ext_ram_high_enable_out <= 1'b1;
      ext_ram_low_enable_out  <= 1'b1;
      io_enable_out           <= 1'b1;
      device_select_out       <= 1'b1;
      write_strobe_n_out      <= 1'b1;
      pll_in_use_out          <= 1'b0;
      clock_mode_fault_out    <= 1'b0;
    end
    else
    begin
      state_reg               <= state_next;
      rst_cnt_reg             <= rst_cnt_next;
      edge_cnt_reg            <= edge_cnt_next;
      slow_cnt_reg            <= slow_cnt_next;
      tck_prev_reg            <= tck_prev_next;
      test_reset_out          <= test_reset_next;
      core_reset_out          <= core_reset_next;
      reset_too_short_out     <= short_next;
      clock_output_out        <= clk_out_next;
      pin_oe_n_out            <= pin_oe_n_next;
      test_data_oe_n_out      <= tdo_oe_n_next;
      ext_rom_enable_out      <= rom_next;
      ext_ram_high_enable_out <= ramh_next;
      ext_ram_low_enable_out  <= raml_next;
      io_enable_out           <= io_next;
      device_select_out       <= device_select_out_next;
      write_strobe_n_out      <= wsn_next;
      pll_in_use_out          <= pll_next;
      clock_mode_fault_out    <= fault_next;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_tms_edge;
    tck_rise && tms_s2_reg;
  endsequence

  sequence s_reset_both;
    !rstn_s2_reg && interrupt_zero_input_s2_reg;
  endsequence

  test_reset_hold_a: assert property (test_reset_out && !tck_rise |=> test_reset_out)
    else $error("test reset dropped without a tck edge");
  test_edge_reset_a: assert property ((s_tms_edge and (edge_cnt_reg == 3'h5)) |=> test_reset_out)
    else $error("six tms-high edges did not reset test controller");
  pin_float_a: assert property (s_reset_both |=> pin_oe_n_out && ext_rom_enable_out)
    else $error("pins not high impedance in reset with interrupt zero");
  tdo_follow_a: assert property (1'b1 |=> test_data_oe_n_out == $past(test_data_oe_n_in))
    else $error("tdo enable not under test control");
  strobes_high_a: assert property (!rstn_s2_reg && !interrupt_zero_input_s2_reg |=>
    !pin_oe_n_out && write_strobe_n_out && device_select_out && io_enable_out)
    else $error("strobes not driven high in reset");
  // the first edge after power-up reset has no earlier toggle to compare against
  clock_runs_a: assert property (!slow_clock_select_in && !$past(slow_clock_select_in)
    && !$past(rst_in)
    |-> clock_output_out != $past(clock_output_out))
    else $error("clock output stopped");
  short_pulse_a: assert property (state_reg == rps_pkg::RPS_RESET && rstn_s2_reg
    && rst_cnt_reg < 3'h6 |=> core_reset_out && reset_too_short_out)
    else $error("short reset pulse released the core");
  long_pulse_a: assert property (!rstn_s2_reg [*6] ##1 rstn_s2_reg |=> !core_reset_out)
    else $error("six-cycle reset did not release the core");
  pll_forced_a: assert property (speed_above_50_in |=> pll_in_use_out)
    else $error("direct clock used above 50 MIPS");
  slow_period_a: assert property (slow_clock_select_in [*8] |-> slow_cnt_reg <= 5'ha)
    else $error("slow clock half period too long");

endmodule : rps_sequencer

// file: rps_board.sv
// board reset source and test-port controller driving the sequencer pins
// assumes the caller times requests from the core clock it is given
module rps_board
(
  input  wire logic clk_in,
  output logic      chip_reset_n_out,
  output logic      test_clock_out,
  output logic      test_mode_select_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    chip_reset_n_out = 1'b1;
    test_clock_out = 1'b0;
    test_mode_select_out = 1'b1;
  end
  // clocks keep running while reset is held; short counts only to provoke a refusal
  task automatic chip_reset(input int cycles);
    @(posedge clk_in) #5 chip_reset_n_out = 1'b0;
    repeat (cycles) @(posedge clk_in);
    #5 chip_reset_n_out = 1'b1;
  endtask : chip_reset
  // tck stays high for 3 core cycles and low for at least 4 so the synchroniser sees it
  task automatic tck_rises(input int n, input logic tms);
    repeat (n)
    begin
      @(posedge clk_in) #5 test_mode_select_out = tms;
      repeat (3) @(posedge clk_in);
      #5 test_clock_out = 1'b1;
      repeat (3) @(posedge clk_in);
      #5 test_clock_out = 1'b0;
    end
    test_mode_select_out = 1'b1; // pull-up
  endtask : tck_rises
endmodule : rps_board

// file: rps_sequencer_tb.sv
// self-checking bench for the reset and test-port sequencer
// assumes the board model drives the reset and test pins
module rps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { string nm; logic [12:0] mask; logic [12:0] val; } rps_note_t;
  logic clk_in = 1'b0, rst_in = 1'b1, chip_reset_n, tck, tms, interrupt_zero_input = 1'b0, tdo_oe_n = 1'b1;
  logic pll = 1'b0, fast = 1'b0, slow = 1'b0;
  logic [5:0]  core = 6'h3f;
  logic [5:0]  strb;
  logic [12:0] obs;
  logic        clock_output, pin_oe_n, tdo_oe_n_o, test_rst, core_rst, too_short, pll_use, fault;
  int          errors = 0, compares = 0, cyc;
  rps_note_t   notes[$];
  rps_note_t   n;
  always #25 clk_in = ~clk_in;
  assign obs = {test_rst, core_rst, pin_oe_n, tdo_oe_n_o, too_short, pll_use, fault, strb};
  rps_board i_rps_board (.clk_in(clk_in), .chip_reset_n_out(chip_reset_n),
    .test_clock_out(tck), .test_mode_select_out(tms));
  rps_sequencer i_rps_sequencer (.clk_in(clk_in), .rst_in(rst_in),
    .chip_reset_n_in(chip_reset_n), .interrupt_zero_input_in(interrupt_zero_input), .test_clock_in(tck),
    .test_mode_select_in(tms), .test_data_oe_n_in(tdo_oe_n), .pll_enable_in(pll),
    .speed_above_50_in(fast), .slow_clock_select_in(slow), .core_rom_enable_in(core[5]),
    .core_ram_high_enable_in(core[4]), .core_ram_low_enable_in(core[3]),
    .core_io_enable_in(core[2]), .core_device_select_in(core[1]),
    .core_write_strobe_n_in(core[0]), .ext_rom_enable_out(strb[5]),
    .ext_ram_high_enable_out(strb[4]), .ext_ram_low_enable_out(strb[3]),
    .io_enable_out(strb[2]), .device_select_out(strb[1]), .write_strobe_n_out(strb[0]),
    .clock_output_out(clock_output), .pin_oe_n_out(pin_oe_n), .test_data_oe_n_out(tdo_oe_n_o),
    .test_reset_out(test_rst), .core_reset_out(core_rst), .reset_too_short_out(too_short),
    .pll_in_use_out(pll_use), .clock_mode_fault_out(fault));
  task automatic report_and_stop;
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic note(input string nm, input logic [12:0] mask, input logic [12:0] val);
    notes.push_back('{nm, mask, val});
  endtask : note
  // the watcher compares every pending note against the settled outputs
  always @(negedge clk_in)
    while (notes.size() != 0)
    begin
      n = notes.pop_front();
      chk(n.nm, obs & n.mask, n.val & n.mask);
    end
  task automatic wait_cko_rise;
    int k;
    k = 0;
    while (!(clock_output === 1'b0))
    begin
      @(posedge clk_in) #5 k++;
      if (k > 64) begin errors++; report_and_stop(); end
    end
    while (!(clock_output === 1'b1))
    begin
      @(posedge clk_in) #5 k++;
      if (k > 64) begin errors++; report_and_stop(); end
    end
  endtask : wait_cko_rise
  task automatic cko_period(output int c);
    wait_cko_rise();
    c = compares;
    cyc = 0;
    fork
      begin
        wait_cko_rise();
      end
      forever @(posedge clk_in) cyc++;
    join_any
    disable fork;
    c = cyc;
  endtask : cko_period
  initial
  begin
    int p;
    void'($urandom(86225));
    repeat (5) @(posedge clk_in);
    #5 rst_in = 1'b0;
    note("powerup", 13'h1800, 13'h1800);
    i_rps_board.chip_reset(3);
    repeat (6) @(posedge clk_in);
    note("short pulse", 13'h0900, 13'h0900);
    #5 core = 6'(($urandom() & 32'h3e));
    fork
      i_rps_board.chip_reset(14);
      begin
        repeat (6) @(posedge clk_in);
        note("reset strobes", 13'h043f, 13'h003f);
        cko_period(p);
        chk("reset clock period", 13'(p), 13'h2);
      end
    join
    repeat (6) @(posedge clk_in);
    note("release", 13'h0900, 13'h0000);
    #5 interrupt_zero_input = 1'b1;
    tdo_oe_n = 1'b0;
    fork
      i_rps_board.chip_reset(8);
      begin
        repeat (6) @(posedge clk_in);
        note("float pins", 13'h0600, 13'h0400);
      end
    join
    interrupt_zero_input = 1'b0;
    tdo_oe_n = 1'b1;
    // the release needs three edges through the synchroniser before strobes follow the core
    repeat (3) @(posedge clk_in);
    repeat (8)
    begin
      @(posedge clk_in) #5 core = 6'($urandom());
      @(posedge clk_in) #5 note("run strobes", 13'h003f, {7'h0, core});
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in) #5 {pll, fast} = 2'(i);
      @(posedge clk_in) #5 note("clock mode", 13'h00c0, {5'h0, pll | fast, fast & ~pll, 6'h0});
    end
    i_rps_board.tck_rises(1, 1'b0);
    repeat (4) @(posedge clk_in);
    note("tms low", 13'h1000, 13'h0000);
    i_rps_board.tck_rises(5, 1'b1);
    repeat (4) @(posedge clk_in);
    note("five rises", 13'h1000, 13'h0000);
    i_rps_board.tck_rises(1, 1'b1);
    repeat (4) @(posedge clk_in);
    note("six rises", 13'h1000, 13'h1000);
    #5 slow = 1'b1;
    repeat (25) @(posedge clk_in);
    cko_period(p);
    chk("slow period", 13'(p >= rps_pkg::SLOW_MIN_CYCLES && p <= rps_pkg::SLOW_MAX_CYCLES), 13'h1);
    repeat (2) @(posedge clk_in);
    report_and_stop();
  end
endmodule : rps_sequencer_tb
